/* File: phybc_ctrl.sv */
// basic mode control register bank of a 10/100 transceiver
// assumes a same-clock negotiation engine and register master;
// straps and TX_EN arrive asynchronously and are synchronised here
//
// Implementation choice: the strobed register port.
`default_nettype none

// How it works
// - power down stops collision test, negotiation kicks and MII; registers stay live
// - isolate bit 10 cuts the MII side, management keeps working
// - writing restart bit 9 restarts negotiation, ignored when bit 12 is clear
// - restart bit reads one until negotiation starts, then clears itself
// - writing zero to restart never disturbs a running negotiation
// - duplex bit 8 loads from strap; forces full or half when negotiation off
// - collision test raises COL well within 512 bit times of TX_EN rising
// - collision test drops COL within 4 bit times of TX_EN falling
// - bits 6 to 0 ignore writes and read as zero
// - negotiation enable overrides forced speed and duplex bits
module phybc_ctrl
    import phybc_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // register port
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [15:0] REG_RDATA,
    // strap pins
    input  wire logic        STRAP_ANEG_EN,
    input  wire logic        STRAP_FULL_DUPLEX,
    // MAC side
    input  wire logic        TX_EN,
    output var  logic        COL,
    // negotiation engine
    output var  logic        AN_RESTART,
    input  wire logic        AN_BUSY,
    input  wire logic        AN_SPEED_100,
    input  wire logic        AN_FULL_DUPLEX,
    // operating mode
    output var  logic        POWER_DOWN,
    output var  logic        MII_ISOLATE,
    output var  logic        LOOPBACK,
    output var  logic        SPEED_100,
    output var  logic        FULL_DUPLEX
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    phybc_ctrl_t     ctrl;
    phybc_an_state_t an_state;
    phybc_an_state_t next_an_state;
    logic            restart;
    logic            restart_set;
    logic            restart_clr;
    logic            ctrl_wr;
    logic            ctrl_rd;
    logic [15:0]     read_word;
    logic            strap_aneg_s1;
    logic            strap_aneg_s2;
    logic            strap_dup_s1;
    logic            strap_dup_s2;
    logic [1:0]      strap_cnt;
    logic            strap_load;
    logic            tx_en_s1;
    logic            tx_en_s2;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    assign ctrl_wr = REG_WR && (REG_ADDR == PHYBC_ADDR_CTRL);
    assign ctrl_rd = REG_RD && (REG_ADDR == PHYBC_ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // strap capture
    // pins are sampled after release, never loaded under reset
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            strap_aneg_s1 <= 1'b0;
            strap_aneg_s2 <= 1'b0;
            strap_dup_s1  <= 1'b0;
            strap_dup_s2  <= 1'b0;
        end
        else
        begin
            strap_aneg_s1 <= STRAP_ANEG_EN;
            strap_aneg_s2 <= strap_aneg_s1;
            strap_dup_s1  <= STRAP_FULL_DUPLEX;
            strap_dup_s2  <= strap_dup_s1;
        end
    end

    // wait until the synchroniser holds a real pin sample
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            strap_cnt <= 2'h0;
        end
        else if (strap_cnt != 2'h3)
        begin
            strap_cnt <= strap_cnt + 2'h1;
        end
    end

    assign strap_load = (strap_cnt == PHYBC_STRAP_SETTLE);

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    // reserved bits 6:0 and bit 15 have no storage at all
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl <= PHYBC_CTRL_RESET;
        end
        else if (strap_load)
        begin
            ctrl.aneg_en     <= strap_aneg_s2;
            ctrl.full_duplex <= strap_dup_s2;
        end
        else if (ctrl_wr)
        begin
            ctrl.loopback    <= REG_WDATA[PHYBC_B_LOOPBACK];
            ctrl.speed_100   <= REG_WDATA[PHYBC_B_SPEED_100];
            ctrl.aneg_en     <= REG_WDATA[PHYBC_B_ANEG_EN];
            ctrl.power_down  <= REG_WDATA[PHYBC_B_POWER_DOWN];
            ctrl.isolate     <= REG_WDATA[PHYBC_B_ISOLATE];
            ctrl.full_duplex <= REG_WDATA[PHYBC_B_DUPLEX];
            ctrl.col_test    <= REG_WDATA[PHYBC_B_COL_TEST];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart request bit
    // the enable bit of the same word decides whether the restart counts
    assign restart_set = ctrl_wr
                         && REG_WDATA[PHYBC_B_RESTART]
                         && REG_WDATA[PHYBC_B_ANEG_EN];

    // the engine's acknowledge or a clear enable bit clears it, a written zero does not
    assign restart_clr = ((an_state == PHYBC_AN_WAIT) && AN_BUSY)
                         || !ctrl.aneg_en;

    // a new request in the acknowledge cycle survives
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            restart <= 1'b0;
        end
        else if (restart_set)
        begin
            restart <= 1'b1;
        end
        else if (restart_clr)
        begin
            restart <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // negotiation kick sequencer
    always_comb
    begin
        next_an_state = an_state;
        case (an_state)
            PHYBC_AN_IDLE:
            begin
                if (restart && ctrl.aneg_en && !ctrl.power_down)
                begin
                    next_an_state = PHYBC_AN_KICK;
                end
            end
            PHYBC_AN_KICK:
            begin
                next_an_state = PHYBC_AN_WAIT;
            end
            PHYBC_AN_WAIT:
            begin
                if (AN_BUSY)
                begin
                    next_an_state = PHYBC_AN_IDLE;
                end
            end
            default:
            begin
                next_an_state = PHYBC_AN_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            an_state <= PHYBC_AN_IDLE;
        end
        else
        begin
            an_state <= next_an_state;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            AN_RESTART <= 1'b0;
        end
        else
        begin
            AN_RESTART <= (next_an_state == PHYBC_AN_KICK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // collision test
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            tx_en_s1 <= 1'b0;
            tx_en_s2 <= 1'b0;
        end
        else
        begin
            tx_en_s1 <= TX_EN;
            tx_en_s2 <= tx_en_s1;
        end
    end

    // three cycles of latency sit far inside both bounds at either speed
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            COL <= 1'b0;
        end
        else
        begin
            COL <= tx_en_s2
                   && ctrl.col_test
                   && !ctrl.power_down
                   && !ctrl.isolate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating mode
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            POWER_DOWN  <= 1'b0;
            MII_ISOLATE <= 1'b0;
            LOOPBACK    <= 1'b0;
            SPEED_100   <= 1'b0;
            FULL_DUPLEX <= 1'b0;
        end
        else
        begin
            POWER_DOWN  <= ctrl.power_down;
            // a powered-down port is cut from the MII as well
            MII_ISOLATE <= ctrl.isolate || ctrl.power_down;
            LOOPBACK    <= ctrl.loopback;
            if (ctrl.aneg_en)
            begin
                SPEED_100   <= AN_SPEED_100;
                FULL_DUPLEX <= AN_FULL_DUPLEX;
            end
            else
            begin
                SPEED_100   <= ctrl.speed_100;
                FULL_DUPLEX <= ctrl.full_duplex;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read back
    always_comb
    begin
        read_word                     = PHYBC_RESET_VALUE;
        read_word[PHYBC_B_LOOPBACK]   = ctrl.loopback;
        read_word[PHYBC_B_SPEED_100]  = ctrl.speed_100;
        read_word[PHYBC_B_ANEG_EN]    = ctrl.aneg_en;
        read_word[PHYBC_B_POWER_DOWN] = ctrl.power_down;
        read_word[PHYBC_B_ISOLATE]    = ctrl.isolate;
        read_word[PHYBC_B_RESTART]    = restart;
        read_word[PHYBC_B_DUPLEX]     = ctrl.full_duplex;
        read_word[PHYBC_B_COL_TEST]   = ctrl.col_test;
    end

    // unmapped addresses and idle cycles return zero
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            REG_RDATA <= 16'h0000;
        end
        else if (ctrl_rd)
        begin
            REG_RDATA <= read_word;
        end
        else
        begin
            REG_RDATA <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

/* File: phybc_pkg.sv */
// constants and types for the basic mode control register bank
// assumes a single 250 MHz device clock shared by every user of the package
`default_nettype none

package phybc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [4:0]  PHYBC_ADDR_CTRL   = 5'h00;
    localparam logic [15:0] PHYBC_RESET_VALUE = 16'h0000;

    // field positions in the control word
    localparam int PHYBC_B_SOFT_RESET = 15;
    localparam int PHYBC_B_LOOPBACK   = 14;
    localparam int PHYBC_B_SPEED_100  = 13;
    localparam int PHYBC_B_ANEG_EN    = 12;
    localparam int PHYBC_B_POWER_DOWN = 11;
    localparam int PHYBC_B_ISOLATE    = 10;
    localparam int PHYBC_B_RESTART    = 9;
    localparam int PHYBC_B_DUPLEX     = 8;
    localparam int PHYBC_B_COL_TEST   = 7;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int PHYBC_CLK_PERIOD_NS = 4;
    localparam int PHYBC_BIT_TIME_NS   = 10;
    localparam int PHYBC_COL_ON_BITS   = 512;
    localparam int PHYBC_COL_OFF_BITS  = 4;
    localparam int PHYBC_COL_ON_MAX    =
        (PHYBC_COL_ON_BITS * PHYBC_BIT_TIME_NS) / PHYBC_CLK_PERIOD_NS;
    localparam int PHYBC_COL_OFF_MAX   =
        (PHYBC_COL_OFF_BITS * PHYBC_BIT_TIME_NS) / PHYBC_CLK_PERIOD_NS;
    localparam int PHYBC_COL_LATENCY   = 3;
    localparam logic [1:0] PHYBC_STRAP_SETTLE = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic aneg_en;
        logic power_down;
        logic isolate;
        logic full_duplex;
        logic col_test;
    } phybc_ctrl_t;

    localparam phybc_ctrl_t PHYBC_CTRL_RESET = '0;

    typedef enum logic [1:0] {
        PHYBC_AN_IDLE = 2'b00,
        PHYBC_AN_KICK = 2'b01,
        PHYBC_AN_WAIT = 2'b11
    } phybc_an_state_t;

endpackage

`default_nettype wire

/* File: phybc_ctrl_props.sv */
// port checker for the basic mode control bank
// assumes binding onto phybc_ctrl, one clock domain
`default_nettype none
module phybc_ctrl_props
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // watched ports
    input wire logic [4:0]  REG_ADDR,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic        TX_EN,
    input wire logic        COL,
    input wire logic        AN_RESTART,
    input wire logic        POWER_DOWN,
    input wire logic        MII_ISOLATE
);
    localparam int off_max = 10;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_bad_rd;
        REG_RD && REG_ADDR != 5'h00;
    endsequence
    sequence s_tx_off;
        $fell(TX_EN);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_reserved_zero: assert property (REG_RDATA[6:0] == 7'h00)
        else $error("reserved bits read nonzero");
    a_unmapped_read: assert property (s_bad_rd |=> REG_RDATA == 16'h0000)
        else $error("unmapped read returned data");
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
        else $error("read data outside answer cycle");
    a_pd_isolates: assert property (POWER_DOWN |-> MII_ISOLATE)
        else $error("power down left MII connected");
    a_pd_no_kick: assert property (POWER_DOWN |-> !AN_RESTART)
        else $error("restart pulse while powered down");
    a_iso_no_col: assert property (MII_ISOLATE |-> !COL)
        else $error("collision shown while isolated");
    a_kick_single: assert property (AN_RESTART |=> !AN_RESTART)
        else $error("restart pulse longer than one cycle");
    a_col_cause: assert property (COL |-> $past(TX_EN, 3))
        else $error("collision without transmit enable");
    a_col_release: assert property (s_tx_off |-> ##[1:off_max] !COL)
        else $error("collision held after transmit end");
endmodule

bind phybc_ctrl phybc_ctrl_props i_props
(
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .TX_EN(TX_EN), .COL(COL), .AN_RESTART(AN_RESTART),
    .POWER_DOWN(POWER_DOWN), .MII_ISOLATE(MII_ISOLATE)
);
`default_nettype wire

/* File: phybc_aneg_model.sv */
// negotiation engine stand-in for the control bank bench
// assumes the bank's clock; DELAY sets how slowly it starts
`default_nettype none
module phybc_aneg_model
#(
    parameter int   RUN     = 20,
    parameter logic RES_SPD = 1'b1,
    parameter logic RES_FD  = 1'b0
)
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // bank side
    input  wire logic       AN_RESTART,
    input  wire logic [7:0] DELAY,
    output var  logic       AN_BUSY,
    output var  logic       AN_SPEED_100,
    output var  logic       AN_FULL_DUPLEX
);
    logic       pend;
    logic [7:0] cnt;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pend    <= 1'b0;
            cnt     <= 8'h00;
            AN_BUSY <= 1'b0;
        end
        else if (AN_RESTART && !AN_BUSY)
        begin
            pend <= 1'b1;
            cnt  <= DELAY;
        end
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else if (pend)
        begin
            // once running, the bank's restart bit no longer matters
            pend    <= 1'b0;
            AN_BUSY <= 1'b1;
            cnt     <= 8'(RUN);
        end
        else
            AN_BUSY <= 1'b0;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            AN_SPEED_100   <= 1'b0;
            AN_FULL_DUPLEX <= 1'b0;
        end
        else if (AN_BUSY && cnt == 8'h00 && !pend)
        begin
            AN_SPEED_100   <= RES_SPD;
            AN_FULL_DUPLEX <= RES_FD;
        end
    end
endmodule
`default_nettype wire

/* File: phybc_ctrl_bench.sv */
// self-checking bench for the basic mode control bank
// assumes phybc_ctrl with bound checker and the negotiation model
`default_nettype none
module phybc_ctrl_bench
    import phybc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        tx_en = 1'b0;
    logic [15:0] rdata;
    logic        col, kick, busy, spd_an, fd_an, pd, iso, spd, fd, lpbk;
    int          fail_count = 0;
    int          compares = 0;
    int          kicks = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (kick === 1'b1) kicks++;
    phybc_ctrl i_dut
    (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .STRAP_ANEG_EN(1'b0),
        .STRAP_FULL_DUPLEX(1'b1), .TX_EN(tx_en), .COL(col), .AN_RESTART(kick),
        .AN_BUSY(busy), .AN_SPEED_100(spd_an), .AN_FULL_DUPLEX(fd_an),
        .POWER_DOWN(pd), .MII_ISOLATE(iso), .LOOPBACK(lpbk), .SPEED_100(spd),
        .FULL_DUPLEX(fd)
    );
    phybc_aneg_model i_peer
    (
        .CLK(clk), .RST(rst), .AN_RESTART(kick), .DELAY(8'h08),
        .AN_BUSY(busy), .AN_SPEED_100(spd_an), .AN_FULL_DUPLEX(fd_an)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk16(rdata, exp);
    endtask
    // mode outputs land one edge after the field
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wait_col(input logic v, input int lim);
        for (int n = 0; n < lim && col !== v; n++) @(posedge clk) #1;
        chk1(col, v);
    endtask
    task automatic wait_busy(input logic v);
        for (int n = 0; n < 100 && busy !== v; n++) @(posedge clk) #1;
        chk1(busy, v);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_start();
        rd_chk(5'h00, 16'h0100);
        chk1(fd, 1'b1);
        wr_reg(5'h00, 16'h807F);
        rd_chk(5'h00, 16'h0000);
        wr_reg(5'h03, 16'h2100);
        rd_chk(5'h03, 16'h0000);
        rd_chk(5'h00, 16'h0000);
    endtask
    task automatic t_forced();
        wr_reg(5'h00, 16'h6300);
        settle();
        chk1(spd, 1'b1);
        chk1(fd, 1'b1);
        chk1(lpbk, 1'b1);
        rd_chk(5'h00, 16'h6100);
        chk16(16'(kicks), 16'h0000);
    endtask
    task automatic t_restart();
        wr_reg(5'h00, 16'h1200);
        rd_chk(5'h00, 16'h1200);
        wr_reg(5'h00, 16'h1000);
        rd_chk(5'h00, 16'h1200);
        wait_busy(1'b1);
        settle();
        chk1(lpbk, 1'b0);
        rd_chk(5'h00, 16'h1000);
        chk16(16'(kicks), 16'h0001);
        wr_reg(5'h00, 16'h1100);
        chk1(busy, 1'b1);
        wait_busy(1'b0);
        settle();
        chk1(spd, 1'b1);
        chk1(fd, 1'b0);
    endtask
    task automatic t_power();
        wr_reg(5'h00, 16'h1A80);
        settle();
        chk1(pd, 1'b1);
        chk1(iso, 1'b1);
        rd_chk(5'h00, 16'h1A80);
        @(posedge clk) tx_en <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk1(col, 1'b0);
        chk16(16'(kicks), 16'h0001);
        @(posedge clk) tx_en <= 1'b0;
        wr_reg(5'h00, 16'h1080);
        wait_busy(1'b1);
        chk16(16'(kicks), 16'h0002);
        wait_busy(1'b0);
    endtask
    task automatic t_collide();
        wr_reg(5'h00, 16'h0480);
        settle();
        chk1(iso, 1'b1);
        @(posedge clk) tx_en <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk1(col, 1'b0);
        wr_reg(5'h00, 16'h0080);
        wait_col(1'b1, PHYBC_COL_ON_MAX);
        chk1(iso, 1'b0);
        @(posedge clk) tx_en <= 1'b0;
        wait_col(1'b0, PHYBC_COL_OFF_MAX);
    endtask
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_start();
        t_forced();
        t_restart();
        t_power();
        t_collide();
        finish_test();
    end
    // runs take well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
